// ---- core/frt_pkg.sv ----
// Package with field layout, codes, reset values and states of the fault response
package frt_pkg;

   // Response setting byte layout
   localparam int MODE_MSB = 7;
   localparam int MODE_LSB = 6;
   localparam int RETRY_MSB = 5;
   localparam int RETRY_LSB = 3;
   localparam int DELAY_MSB = 2;
   localparam int DELAY_LSB = 0;

   // Setting value after reset: shut down, no retry, one delay unit
   localparam logic [7:0] SETTING_RESET = 8'h80;

   // Response mode codes
   localparam logic [1:0] MODE_IGNORE = 2'h0;
   localparam logic [1:0] MODE_RIDE = 2'h1;
   localparam logic [1:0] MODE_SHUTDOWN = 2'h2;
   localparam logic [1:0] MODE_HOLD_OFF = 2'h3;

   // Retry field codes
   localparam logic [2:0] RETRY_NONE = 3'h0;
   localparam logic [2:0] RETRY_ENDLESS = 3'h7;

   // Reset values of the control state
   localparam logic [2:0] RETRY_LEFT_RESET = 3'h0;
   localparam logic FLAG_RESET = 1'b0;

   // Synchroniser length for pin inputs
   localparam int SYNC_STAGES = 2;

   // Handler states, one-hot
   typedef enum logic [6:0] {
      ST_OFF = 7'h01,
      ST_RUN = 7'h02,
      ST_RIDE = 7'h04,
      ST_HOLD = 7'h08,
      ST_WAIT = 7'h10,
      ST_TRY = 7'h20,
      ST_LATCH = 7'h40
   } frt_state_e;

endpackage : frt_pkg

// ---- core/frt_sync.sv ----
// Two flip-flop synchroniser for a level arriving from a pin
`timescale 1ns/1ns
module frt_sync (
   input wire logic clk,
   input wire logic rst,
   input wire logic async_in,
   output logic sync_out
);

   logic meta;
   logic next_meta;
   logic next_sync_out;

   // First stage feeds only the second stage
   always_comb begin
      next_meta = async_in;
      next_sync_out = meta;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta <= next_meta;
         sync_out <= next_sync_out;
      end
   end

endmodule : frt_sync

// ---- core/frt_delay_timer.sv ----
// Delay timer counting a power-of-two number of programmable time units
`timescale 1ns/1ns
module frt_delay_timer #(
   parameter int UNIT_W = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire logic clear,
   input wire logic [UNIT_W-1:0] unit_cycles,
   input wire logic [2:0] units_log2,
   output logic done
);

   if (UNIT_W < 1 || UNIT_W > 24) begin : g_chk
      $error("frt_delay_timer: UNIT_W must be 1 to 24");
   end

   logic active;
   logic [UNIT_W-1:0] pre_cnt;
   logic [7:0] unit_cnt;
   logic next_active;
   logic [UNIT_W-1:0] next_pre_cnt;
   logic [7:0] next_unit_cnt;
   logic next_done;
   logic [UNIT_W-1:0] last_pre;
   logic [7:0] last_unit;

   // A zero unit length counts as one cycle so the timer always ends
   always_comb begin
      last_pre = (unit_cycles == '0) ? '0
                 : unit_cycles - {{(UNIT_W-1){1'b0}}, 1'b1};
      last_unit = (8'h01 << units_log2) - 8'h01;
      next_active = active;
      next_pre_cnt = pre_cnt;
      next_unit_cnt = unit_cnt;
      next_done = 1'b0;
      if (start) begin
         // Start beats clear so a new interval is never lost
         next_active = 1'b1;
         next_pre_cnt = '0;
         next_unit_cnt = 8'h00;
      end else if (clear) begin
         next_active = 1'b0;
         next_pre_cnt = '0;
         next_unit_cnt = 8'h00;
      end else if (active) begin
         if (pre_cnt == last_pre) begin
            next_pre_cnt = '0;
            if (unit_cnt == last_unit) begin
               next_active = 1'b0;
               next_done = 1'b1;
            end else begin
               next_unit_cnt = unit_cnt + 8'h01;
            end
         end else begin
            next_pre_cnt = pre_cnt + {{(UNIT_W-1){1'b0}}, 1'b1};
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         active <= 1'b0;
         pre_cnt <= '0;
         unit_cnt <= 8'h00;
         done <= 1'b0;
      end else begin
         active <= next_active;
         pre_cnt <= next_pre_cnt;
         unit_cnt <= next_unit_cnt;
         done <= next_done;
      end
   end

endmodule : frt_delay_timer

// ---- core/frt_fault_response.sv ----
// Fault response and retry handler for one monitored converter fault
`timescale 1ns/1ns

module frt_fault_response #(
   parameter int UNIT_W = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic setting_wr,
   input wire logic [7:0] setting_wdata,
   output logic [7:0] setting_rdata,
   input wire logic [UNIT_W-1:0] time_unit_cycles,
   input wire logic fault_present,
   input wire logic ctrl_pin,
   input wire logic operation_on,
   input wire logic clear_faults,
   input wire logic status_bit_clear,
   input wire logic other_shutdown,
   output logic output_enable,
   output logic fault_status,
   output logic fault_latched,
   output logic retrying,
   output logic [2:0] retry_remaining
);

   if (UNIT_W < 1 || UNIT_W > 24) begin : g_chk
      $error("frt_fault_response: UNIT_W must be 1 to 24");
   end

   // Field layout must fill the byte with three adjacent fields
   if (frt_pkg::MODE_MSB != 7
       || frt_pkg::MODE_LSB != frt_pkg::RETRY_MSB + 1
       || frt_pkg::RETRY_LSB != frt_pkg::DELAY_MSB + 1
       || frt_pkg::RETRY_MSB - frt_pkg::RETRY_LSB != 2
       || frt_pkg::DELAY_MSB - frt_pkg::DELAY_LSB != 2
       || frt_pkg::DELAY_LSB != 0) begin : g_layout
      $error("frt_fault_response: response byte layout is inconsistent");
   end

   // Registered state and its next values
   frt_pkg::frt_state_e state;
   frt_pkg::frt_state_e next_state;
   logic [7:0] next_setting;
   logic next_output_enable;
   logic next_fault_status;
   logic next_fault_latched;
   logic next_retrying;
   logic [2:0] next_retry_remaining;

   // Decoded controls and timer handshake
   logic ctrl_sync;
   logic cmd_on;
   logic clear_req;
   logic [1:0] mode;
   logic [2:0] retry_field;
   logic [2:0] delay_code;
   logic endless;
   logic timer_start;
   logic timer_clear;
   logic timer_done;
   logic go_shutdown;
   logic status_set;

   // Remote control pin is asynchronous to the converter clock
   // An off pulse on it must cover one clock edge to be seen, and reaches the handler two clocks later
   frt_sync u_ctrl_sync (
      .clk(clk),
      .rst(rst),
      .async_in(ctrl_pin),
      .sync_out(ctrl_sync)
   );

   // Ride-through and retry spacing both use one timer; they never overlap
   // A start always reloads it, so a new fault never inherits old time
   frt_delay_timer #(
      .UNIT_W(UNIT_W)
   ) u_timer (
      .clk(clk),
      .rst(rst),
      .start(timer_start),
      .clear(timer_clear),
      .unit_cycles(time_unit_cycles),
      .units_log2(delay_code),
      .done(timer_done)
   );

   // Fields of the stored response byte
   assign mode = setting_rdata[frt_pkg::MODE_MSB:frt_pkg::MODE_LSB];
   assign retry_field = setting_rdata[frt_pkg::RETRY_MSB:frt_pkg::RETRY_LSB];
   assign delay_code = setting_rdata[frt_pkg::DELAY_MSB:frt_pkg::DELAY_LSB];
   assign endless = (retry_field == frt_pkg::RETRY_ENDLESS);

   // Output is commanded on only when both pin and command agree
   assign cmd_on = ctrl_sync & operation_on;
   assign clear_req = status_bit_clear | clear_faults;

   // Response byte: a write lands on the edge that takes the strobe;
   // a changed field acts at the next decision that uses it
   always_comb begin
      next_setting = setting_rdata;
      if (setting_wr) begin
         next_setting = setting_wdata;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         setting_rdata <= frt_pkg::SETTING_RESET;
      end else begin
         setting_rdata <= next_setting;
      end
   end

   // Next-state logic for the handler, its flags and the retry counter
   always_comb begin
      next_state = state;
      next_fault_latched = fault_latched;
      next_retry_remaining = retry_remaining;
      timer_start = 1'b0;
      timer_clear = 1'b0;
      go_shutdown = 1'b0;
      status_set = 1'b0;

      case (state)
         frt_pkg::ST_OFF: begin
            // Turning back on after an off command clears the fault
            if (cmd_on) begin
               next_state = frt_pkg::ST_RUN;
               next_fault_latched = 1'b0;
               next_retry_remaining = retry_field;
            end
         end
         frt_pkg::ST_RUN: begin
            if (fault_present) begin
               status_set = 1'b1;
               case (mode)
                  frt_pkg::MODE_IGNORE: begin
                     next_state = frt_pkg::ST_RUN;
                  end
                  frt_pkg::MODE_RIDE: begin
                     next_state = frt_pkg::ST_RIDE;
                     timer_start = 1'b1;
                  end
                  frt_pkg::MODE_SHUTDOWN: begin
                     go_shutdown = 1'b1;
                  end
                  frt_pkg::MODE_HOLD_OFF: begin
                     next_state = frt_pkg::ST_HOLD;
                  end
                  default: begin
                     next_state = frt_pkg::ST_RUN;
                  end
               endcase
            end
         end
         frt_pkg::ST_RIDE: begin
            // Fault gone before the delay ends: carry on quietly
            if (!fault_present) begin
               next_state = frt_pkg::ST_RUN;
               timer_clear = 1'b1;
            end else if (timer_done) begin
               go_shutdown = 1'b1;
            end
         end
         frt_pkg::ST_HOLD: begin
            // Output comes back by itself once the fault is gone
            if (!fault_present) begin
               next_state = frt_pkg::ST_RUN;
            end
         end
         frt_pkg::ST_WAIT: begin
            // Spacing elapsed: start one restart attempt
            if (clear_req) begin
               next_state = frt_pkg::ST_RUN;
               next_retry_remaining = retry_field;
               timer_clear = 1'b1;
            end else if (timer_done) begin
               next_state = frt_pkg::ST_TRY;
               timer_start = 1'b1;
               // Endless mode leaves the counter at its loaded value
               if (!endless) begin
                  next_retry_remaining = retry_remaining - 3'h1;
               end
            end
         end
         frt_pkg::ST_TRY: begin
            // Attempt succeeds when a full spacing passes without fault
            if (clear_req) begin
               next_state = frt_pkg::ST_RUN;
               next_retry_remaining = retry_field;
               timer_clear = 1'b1;
            end else if (fault_present) begin
               status_set = 1'b1;
               // Failed attempt: wait again, or give up with none left
               if (endless || retry_remaining != 3'h0) begin
                  next_state = frt_pkg::ST_WAIT;
                  timer_start = 1'b1;
               end else begin
                  next_state = frt_pkg::ST_LATCH;
                  next_fault_latched = 1'b1;
                  timer_clear = 1'b1;
               end
            end else if (timer_done) begin
               next_state = frt_pkg::ST_RUN;
               next_retry_remaining = retry_field;
            end
         end
         frt_pkg::ST_LATCH: begin
            // Stays off until one of the clearing actions
            if (clear_req) begin
               next_state = frt_pkg::ST_RUN;
               next_fault_latched = 1'b0;
               next_retry_remaining = retry_field;
            end
         end
         default: begin
            next_state = frt_pkg::ST_OFF;
         end
      endcase

      // Common shutdown path for ride-through expiry and shutdown mode
      // A fresh shutdown reloads the counter, so each fault gets all tries
      if (go_shutdown) begin
         next_retry_remaining = retry_field;
         if (retry_field == frt_pkg::RETRY_NONE) begin
            next_state = frt_pkg::ST_LATCH;
            next_fault_latched = 1'b1;
            timer_clear = 1'b1;
         end else begin
            next_state = frt_pkg::ST_WAIT;
            timer_start = 1'b1;
         end
      end

      // Another fault forcing shutdown ends any retry sequence
      // The latched flag is left alone: that cause has its own monitor
      if (other_shutdown && state != frt_pkg::ST_OFF) begin
         next_state = frt_pkg::ST_LATCH;
         timer_start = 1'b0;
         timer_clear = 1'b1;
      end

      // Off command wins over everything and arms the off-on clear
      // Pin and command share one path, so either one alone turns off
      if (!cmd_on) begin
         next_state = frt_pkg::ST_OFF;
         timer_start = 1'b0;
         timer_clear = 1'b1;
      end
   end

   // Output and retrying flags follow the next state; fault status follows detections and clears
   always_comb begin
      next_output_enable = cmd_on && (next_state == frt_pkg::ST_RUN
                                      || next_state == frt_pkg::ST_RIDE
                                      || next_state == frt_pkg::ST_TRY);
      next_retrying = (next_state == frt_pkg::ST_WAIT)
                      || (next_state == frt_pkg::ST_TRY);
      // A new detection in the clearing cycle keeps the bit set
      next_fault_status = status_set
                          || (fault_status && !clear_req
                              && !(state == frt_pkg::ST_OFF && cmd_on));
   end

   // Handler registers; reset also clears any latched fault
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= frt_pkg::ST_OFF;
         fault_latched <= frt_pkg::FLAG_RESET;
         retry_remaining <= frt_pkg::RETRY_LEFT_RESET;
      end else begin
         state <= next_state;
         fault_latched <= next_fault_latched;
         retry_remaining <= next_retry_remaining;
      end
   end

   // Flag registers, so every output comes straight from a flip-flop
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         output_enable <= frt_pkg::FLAG_RESET;
         fault_status <= frt_pkg::FLAG_RESET;
         retrying <= frt_pkg::FLAG_RESET;
      end else begin
         output_enable <= next_output_enable;
         fault_status <= next_fault_status;
         retrying <= next_retrying;
      end
   end

endmodule : frt_fault_response

// ---- verif/frt_fault_response_checker.sv ----
// Checker with the port-level relations of the fault response handler
`timescale 1ns/1ns
module frt_fault_response_checker #(
   parameter int UNIT_W = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic setting_wr,
   input wire logic [7:0] setting_wdata,
   input wire logic [7:0] setting_rdata,
   input wire logic [UNIT_W-1:0] time_unit_cycles,
   input wire logic fault_present,
   input wire logic ctrl_pin,
   input wire logic operation_on,
   input wire logic clear_faults,
   input wire logic status_bit_clear,
   input wire logic other_shutdown,
   input wire logic output_enable,
   input wire logic fault_status,
   input wire logic fault_latched,
   input wire logic retrying,
   input wire logic [2:0] retry_remaining
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // Stored fields, as the handler decides from them
   wire logic [1:0] mode = setting_rdata[7:6];
   wire logic [2:0] rty = setting_rdata[5:3];

   chk_status_seen: assert property (
      output_enable && fault_present |=> fault_status)
      else $error("fault status not set on detection");
   chk_hold_off_drop: assert property (
      output_enable && mode == 2'h3 && fault_present |=> !output_enable)
      else $error("hold-off mode kept output on");
   chk_shut_drop: assert property (
      output_enable && mode == 2'h2 && fault_present |=> !output_enable)
      else $error("shutdown mode kept output on");
   chk_latched_off: assert property (
      fault_latched |-> !output_enable)
      else $error("output on while latched");
   chk_clear_latch: assert property (
      fault_latched && (clear_faults || status_bit_clear) && operation_on
      && ctrl_pin |=> !fault_latched)
      else $error("clear left the fault latched");
   chk_off_priority: assert property (
      !operation_on |=> !output_enable)
      else $error("output on while commanded off");
   chk_pin_off: assert property (
      !ctrl_pin [*3] |=> !output_enable)
      else $error("output on while pin commanded off");
   chk_retry_step: assert property (
      retrying && $rose(output_enable) && rty != 3'h7
      |-> retry_remaining == $past(retry_remaining) - 3'h1)
      else $error("retry counter did not step");
   chk_zero_no_retry: assert property (
      rty == 3'h0 && !retrying |=> !retrying)
      else $error("retry started with zero retries");
   chk_endless_hold: assert property (
      rty == 3'h7 && !fault_latched |=> !fault_latched)
      else $error("endless retry latched off");
   chk_wait_gap: assert property (
      $rose(retrying) |-> !output_enable [*2])
      else $error("restart before spacing");

   // Main scenarios reached
   cover property ($rose(fault_latched));
   cover property ($rose(retrying));
   cover property (mode == 2'h1 && fault_present && output_enable);
endmodule : frt_fault_response_checker

// ---- verif/frt_host.sv ----
// Host controller model driving setting, command and clear inputs
`timescale 1ns/1ns
module frt_host (
   input wire logic clk,
   output logic setting_wr,
   output logic [7:0] setting_wdata,
   output logic operation_on,
   output logic ctrl_pin,
   output logic clear_faults,
   output logic status_bit_clear
);
   // Output commanded on from the start, no strobes
   initial begin
      setting_wr = 1'b0;
      setting_wdata = 8'h00;
      operation_on = 1'b1;
      ctrl_pin = 1'b1;
      clear_faults = 1'b0;
      status_bit_clear = 1'b0;
   end

   // One-cycle write; data inverted after so a late sample shows up
   task wr(input logic [7:0] v);
      setting_wr = 1'b1;
      setting_wdata = v;
      @(posedge clk);
      #2;
      setting_wr = 1'b0;
      setting_wdata = ~v;
   endtask : wr

   // One-cycle clear by command or by status bit
   task clr(input int k);
      clear_faults = (k == 1);
      status_bit_clear = (k == 0);
      @(posedge clk);
      #2;
      clear_faults = 1'b0;
      status_bit_clear = 1'b0;
   endtask : clr

   // Output commanded off then on: 0 command, 1 pin, 2 both
   // Three clocks off so the pin gets through its synchroniser
   task off_on(input int how);
      operation_on = (how == 1);
      ctrl_pin = (how == 0);
      repeat (3) @(posedge clk);
      #2;
      operation_on = 1'b1;
      ctrl_pin = 1'b1;
   endtask : off_on
endmodule : frt_host

// ---- verif/testbench.sv ----
// Self-checking testbench of the fault response handler
`timescale 1ns/1ns
module testbench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic fault_present = 1'b0;
   logic other_shutdown = 1'b0;
   logic [15:0] time_unit_cycles = 16'h0001;
   logic setting_wr, operation_on, ctrl_pin, clear_faults, status_bit_clear;
   logic [7:0] setting_wdata, setting_rdata;
   logic output_enable, fault_status, fault_latched, retrying;
   logic [2:0] retry_remaining;
   int n_errors = 0;
   int checked = 0;

   always #25 clk = ~clk;

   frt_fault_response #(.UNIT_W(16)) dut (
      .clk(clk), .rst(rst), .setting_wr(setting_wr),
      .setting_wdata(setting_wdata), .setting_rdata(setting_rdata),
      .time_unit_cycles(time_unit_cycles), .fault_present(fault_present),
      .ctrl_pin(ctrl_pin), .operation_on(operation_on),
      .clear_faults(clear_faults), .status_bit_clear(status_bit_clear),
      .other_shutdown(other_shutdown), .output_enable(output_enable),
      .fault_status(fault_status), .fault_latched(fault_latched),
      .retrying(retrying), .retry_remaining(retry_remaining));

   frt_host host (
      .clk(clk), .setting_wr(setting_wr), .setting_wdata(setting_wdata),
      .operation_on(operation_on), .ctrl_pin(ctrl_pin),
      .clear_faults(clear_faults), .status_bit_clear(status_bit_clear));

   // Compare and count
   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask : chk

   // Inputs always change 2 ns after the edge
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : cyc

   task final_report();
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : final_report

   // Shutdown mode, fault held; attempts counted by the model
   task shut(input int r);
      int d, n, tries, offn;
      logic prev;
      d = $urandom % 3;
      time_unit_cycles = 16'($urandom % 3 + 1);
      n = (1 << d) * int'(time_unit_cycles);
      host.wr({2'h2, 3'(r), 3'(d)});
      tries = 0;
      offn = 0;
      prev = 1'b1;
      fault_present = 1'b1;
      repeat (400) begin
         cyc(1);
         if (output_enable === 1'b1 && !prev) begin
            tries++;
            chk("gap ok", 8'h01, {7'h0, offn >= n});
            offn = 0;
         end
         if (output_enable !== 1'b1)
            offn++;
         if (tries == 0 && offn == 1)
            chk("retrying", {7'h0, r != 0}, {7'h0, retrying});
         prev = output_enable;
         if (fault_latched === 1'b1 || tries == 8)
            break;
      end
      chk("tries", 8'(r == 7 ? 8 : r), 8'(tries));
      chk("latched", {7'h0, r != 7}, {7'h0, fault_latched});
      fault_present = 1'b0;
      if (r == 7 || r % 3 == 2)
         host.off_on($urandom % 3);
      else
         host.clr(r % 2);
      cyc(3);
      chk("out on", 8'h01, {7'h0, output_enable});
      chk("reload", 8'(r), {5'h0, retry_remaining});
      $display("test retry %0d done", r);
   endtask : shut

   // Hang guard, well beyond the expected run
   initial begin
      #(50 * 20000);
      n_errors++;
      final_report();
   end

   initial begin
      void'($urandom(92));
      cyc(4);
      chk("reset set", 8'h80, setting_rdata);
      rst = 1'b0;
      cyc(4);
      chk("on", 8'h01, {7'h0, output_enable});
      host.wr(8'h00);
      fault_present = 1'b1;
      cyc(5);
      chk("ignore on", 8'h01, {7'h0, output_enable});
      chk("status", 8'h01, {7'h0, fault_status});
      fault_present = 1'b0;
      host.wr(8'hC0);
      fault_present = 1'b1;
      cyc(3);
      chk("hold off", 8'h00, {7'h0, output_enable});
      fault_present = 1'b0;
      cyc(2);
      chk("hold back", 8'h01, {7'h0, output_enable});
      $display("test modes done");
      for (int r = 0; r < 8; r++)
         shut(r);
      time_unit_cycles = 16'h0002;
      host.wr(8'h41);
      fault_present = 1'b1;
      cyc(1);
      fault_present = 1'b0;
      cyc(8);
      chk("ride short", 8'h01, {7'h0, output_enable});
      fault_present = 1'b1;
      cyc(5);
      chk("ride on", 8'h01, {7'h0, output_enable});
      cyc(1);
      chk("ride end", 8'h01, {7'h0, fault_latched});
      chk("ride off", 8'h00, {7'h0, output_enable});
      rst = 1'b1;
      fault_present = 1'b0;
      cyc(2);
      chk("rst latch", 8'h00, {7'h0, fault_latched});
      chk("rst set", 8'h80, setting_rdata);
      rst = 1'b0;
      cyc(4);
      other_shutdown = 1'b1;
      cyc(1);
      other_shutdown = 1'b0;
      cyc(1);
      chk("other off", 8'h00, {7'h0, output_enable});
      host.clr(1);
      cyc(2);
      chk("other clr", 8'h01, {7'h0, output_enable});
      $display("test ride reset done");
      final_report();
   end
endmodule : testbench

bind frt_fault_response frt_fault_response_checker #(.UNIT_W(UNIT_W)) u_chk (
   .clk(clk), .rst(rst), .setting_wr(setting_wr),
   .setting_wdata(setting_wdata), .setting_rdata(setting_rdata),
   .time_unit_cycles(time_unit_cycles), .fault_present(fault_present),
   .ctrl_pin(ctrl_pin), .operation_on(operation_on),
   .clear_faults(clear_faults), .status_bit_clear(status_bit_clear),
   .other_shutdown(other_shutdown), .output_enable(output_enable),
   .fault_status(fault_status), .fault_latched(fault_latched),
   .retrying(retrying), .retry_remaining(retry_remaining));
